// File: rtl/iosvl_pkg.sv
// package: offsets, field positions, reset values and codes of the io status and velocity limit block
package iosvl_pkg;
	// register offsets as printed
	localparam logic [15:0] IOSVL_OFS_IO_STATE    = 16'h0802;
	localparam logic [15:0] IOSVL_OFS_INPUT_STATE = 16'h081e;
	localparam logic [15:0] IOSVL_OFS_OUT_STATE   = 16'h0820;
	localparam logic [15:0] IOSVL_OFS_SAFE_OFF    = 16'h084c;
	localparam logic [15:0] IOSVL_OFS_MAX_VEL     = 16'h1120;
	// field positions
	localparam int          IOSVL_IO_IN_LSB       = 0;
	localparam int          IOSVL_IO_OUT_LSB      = 8;
	localparam int          IOSVL_NUM_IN          = 4;
	localparam int          IOSVL_NUM_OUT         = 2;
	localparam int          IOSVL_NUM_LIM         = 2;
	// velocity setting range and reset
	localparam logic [31:0] IOSVL_VMAX_RESET      = 32'h0000_3390;
	localparam logic [31:0] IOSVL_VMAX_MIN        = 32'h0000_0001;
	localparam logic [31:0] IOSVL_VMAX_MAX        = 32'h7fff_ffff;
	// error codes
	localparam logic [15:0] IOSVL_ERR_NONE        = 16'h0000;
	localparam logic [15:0] IOSVL_ERR_SAFE_OFF    = 16'h0514;
	localparam logic [15:0] IOSVL_ERR_LIMIT_SW    = 16'h0001;
	// sync depth for pin inputs
	localparam int          IOSVL_SYNC_STAGES     = 3;
	// power stage states
	typedef enum logic [2:0] {
		IOSVL_ST_OFF   = 3'b001,
		IOSVL_ST_ON    = 3'b010,
		IOSVL_ST_FAULT = 3'b100
	} iosvl_pwr_e;
endpackage : iosvl_pkg

// File: rtl/iosvl_sync.sv
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module iosvl_sync
	import iosvl_pkg::*;
#(
	parameter int  WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] q_nxt;

	// change accepted only when stages two and three agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			assign q_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : q_o[g];
		end
	endgenerate

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			q_o  <= RST_VAL;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_o  <= q_nxt;
		end
	end
endmodule : iosvl_sync

// File: rtl/iosvl_top.sv
// module: io status words, velocity limit and drive reactions
//
// Function
// - the active velocity limit is the least of the configured maximum, motor maximum and input-selected limit.
// - the configured maximum accepts 1 to 2147483647, resets to 13200 and takes effect immediately.
// - the combined 16-bit state word holds inputs in bits 0-3 and outputs in bits 8-9.
// - each status bit is one when its line is active and zero otherwise.
// - the input state word holds input lines zero to three in bits 0-3, other bits zero.
// - the output state word holds output line zero in bit 0 and one in bit 1, other bits zero.
// - the safe-torque-off channels appear only in their own word, never in the input word.
// - the safe-off word holds channel a in bit 0 and channel b in bit 1.
// - the display port can read the states but has no path to change them.
// - safe torque off while the power stage is on disables it and raises error 1300.
// - a triggered enabled limit switch raises an error indication.
// - each limit switch is enabled by configuration and read as normally closed or open.
// - the holding brake is engaged whenever the power stage is disabled.
`timescale 1ns/1ns
module iosvl_top
	import iosvl_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	// parameter access port
	input  wire logic [15:0] par_addr_i,
	input  wire logic        par_rd_i,
	input  wire logic        par_wr_i,
	input  wire logic [31:0] par_wdata_i,
	output logic      [31:0] par_rdata_o,
	output logic             par_ack_o,
	output logic             par_err_o,
	// local display, read only
	input  wire logic [15:0] disp_addr_i,
	output logic      [15:0] disp_data_o,
	// lines
	input  wire logic        input_line_zero_i,
	input  wire logic        input_line_one_i,
	input  wire logic        input_line_two_i,
	input  wire logic        input_line_three_i,
	input  wire logic        output_line_zero_i,
	input  wire logic        output_line_one_i,
	input  wire logic        safe_off_channel_a_i,
	input  wire logic        safe_off_channel_b_i,
	// velocity limit sources
	input  wire logic [31:0] motor_vel_max_i,
	input  wire logic [31:0] input_vel_lim_i,
	input  wire logic        input_vel_lim_en_i,
	// limit switches
	input  wire logic [1:0]  limit_sw_i,
	input  wire logic [1:0]  limit_sw_en_i,
	input  wire logic [1:0]  limit_sw_nc_i,
	// power stage control
	input  wire logic        enable_req_i,
	input  wire logic        fault_clear_i,
	output logic             power_stage_on_o,
	output logic             brake_engage_o,
	output logic      [31:0] vel_limit_o,
	output logic             error_o,
	output logic      [15:0] error_code_o
);
	// ******************************
	// reset release
	// ******************************
	logic       rst_s1_r;
	logic       rst_n;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1_r <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n    <= rst_s1_r;
		end
	end

	// ******************************
	// line synchronisers
	// ******************************
	localparam int NPIN = IOSVL_NUM_IN + IOSVL_NUM_OUT + 2 + IOSVL_NUM_LIM;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_sync;
	logic [3:0]      in_st;
	logic [1:0]      out_st;
	logic [1:0]      sto_st;
	logic [1:0]      lim_raw;

	assign pin_raw = {limit_sw_i, safe_off_channel_b_i, safe_off_channel_a_i,
	                  output_line_one_i, output_line_zero_i,
	                  input_line_three_i, input_line_two_i, input_line_one_i, input_line_zero_i};

	// safe-off lines idle high (24 v wired when unused)
	iosvl_sync #(
		.WIDTH   (NPIN),
		.RST_VAL ({{IOSVL_NUM_LIM{1'b0}}, 2'b11, {(IOSVL_NUM_IN + IOSVL_NUM_OUT){1'b0}}})
	) u_sync (
		.clk_i   (ref_clk_i),
		.rst_n_i (rst_n),
		.d_i     (pin_raw),
		.q_o     (pin_sync)
	);

	assign in_st   = pin_sync[3:0];
	assign out_st  = pin_sync[5:4];
	assign sto_st  = pin_sync[7:6];
	assign lim_raw = pin_sync[9:8];

	// ******************************
	// status words
	// ******************************
	logic [15:0] io_state_word_r;
	logic [15:0] input_state_word_r;
	logic [15:0] output_state_word_r;
	logic [15:0] safe_off_input_word_r;
	logic [15:0] io_state_nxt;
	logic [15:0] input_state_nxt;
	logic [15:0] output_state_nxt;
	logic [15:0] safe_off_nxt;

	assign io_state_nxt     = {6'h00, out_st, 4'h0, in_st};
	assign input_state_nxt  = {12'h000, in_st};
	assign output_state_nxt = {14'h0000, out_st};
	assign safe_off_nxt     = {14'h0000, sto_st};

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			io_state_word_r       <= 16'h0000;
			input_state_word_r    <= 16'h0000;
			output_state_word_r   <= 16'h0000;
			safe_off_input_word_r <= 16'h0000;
		end else begin
			io_state_word_r       <= io_state_nxt;
			input_state_word_r    <= input_state_nxt;
			output_state_word_r   <= output_state_nxt;
			safe_off_input_word_r <= safe_off_nxt;
		end
	end

	// ******************************
	// velocity setting and limit
	// ******************************
	logic [31:0] max_velocity_setting_r;
	logic [31:0] vel_limit_nxt;
	logic [31:0] vmin_a;
	logic        hit_io;
	logic        hit_di;
	logic        hit_do;
	logic        hit_sto;
	logic        hit_vmax;
	logic        hit_any;
	logic        wr_in_range;
	logic        wr_vmax;

	assign hit_io      = (par_addr_i == IOSVL_OFS_IO_STATE);
	assign hit_di      = (par_addr_i == IOSVL_OFS_INPUT_STATE);
	assign hit_do      = (par_addr_i == IOSVL_OFS_OUT_STATE);
	assign hit_sto     = (par_addr_i == IOSVL_OFS_SAFE_OFF);
	assign hit_vmax    = (par_addr_i == IOSVL_OFS_MAX_VEL);
	assign hit_any     = hit_io | hit_di | hit_do | hit_sto | hit_vmax;
	assign wr_in_range = (par_wdata_i >= IOSVL_VMAX_MIN) && (par_wdata_i <= IOSVL_VMAX_MAX);
	assign wr_vmax     = par_wr_i & hit_vmax & wr_in_range;

	assign vmin_a        = (max_velocity_setting_r < motor_vel_max_i) ? max_velocity_setting_r : motor_vel_max_i;
	assign vel_limit_nxt = (input_vel_lim_en_i && (input_vel_lim_i < vmin_a)) ? input_vel_lim_i : vmin_a;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			max_velocity_setting_r <= IOSVL_VMAX_RESET;
		end else if (wr_vmax) begin
			max_velocity_setting_r <= par_wdata_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			vel_limit_o <= IOSVL_VMAX_RESET;
		end else begin
			vel_limit_o <= vel_limit_nxt;
		end
	end

	// ******************************
	// parameter access
	// ******************************
	logic [31:0] rd_mux;
	logic        acc;
	logic        acc_err;

	assign rd_mux = hit_io   ? {16'h0000, io_state_word_r} :
	                hit_di   ? {16'h0000, input_state_word_r} :
	                hit_do   ? {16'h0000, output_state_word_r} :
	                hit_sto  ? {16'h0000, safe_off_input_word_r} :
	                hit_vmax ? max_velocity_setting_r : 32'h0000_0000;
	assign acc     = par_rd_i | par_wr_i;
	// error: unmapped, write to read-only, or out-of-range value
	assign acc_err = ~hit_any | (par_wr_i & ~hit_vmax) | (par_wr_i & hit_vmax & ~wr_in_range);

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			par_rdata_o <= 32'h0000_0000;
			par_ack_o   <= 1'b0;
			par_err_o   <= 1'b0;
		end else begin
			par_rdata_o <= (par_rd_i && hit_any) ? rd_mux : 32'h0000_0000;
			par_ack_o   <= acc;
			par_err_o   <= acc & acc_err;
		end
	end

	// ******************************
	// local display (read only)
	// ******************************
	logic [15:0] disp_nxt;

	assign disp_nxt = (disp_addr_i == IOSVL_OFS_IO_STATE)    ? io_state_word_r :
	                  (disp_addr_i == IOSVL_OFS_INPUT_STATE) ? input_state_word_r :
	                  (disp_addr_i == IOSVL_OFS_OUT_STATE)   ? output_state_word_r :
	                  (disp_addr_i == IOSVL_OFS_SAFE_OFF)    ? safe_off_input_word_r : 16'h0000;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			disp_data_o <= 16'h0000;
		end else begin
			disp_data_o <= disp_nxt;
		end
	end

	// ******************************
	// limit switches
	// ******************************
	logic [1:0] lim_trig;
	logic       lim_hit;

	genvar g;
	generate
		for (g = 0; g < IOSVL_NUM_LIM; g++) begin : g_lim
			// normally closed: open contact (low) means triggered
			assign lim_trig[g] = limit_sw_en_i[g] & (limit_sw_nc_i[g] ? ~lim_raw[g] : lim_raw[g]);
		end
	endgenerate
	assign lim_hit = |lim_trig;

	// ******************************
	// power stage state
	// ******************************
	iosvl_pwr_e  st_r;
	iosvl_pwr_e  st_nxt;
	logic [15:0] err_nxt;
	logic        sto_trig;

	// either channel low triggers safe torque off
	assign sto_trig = ~(&sto_st);

	// fault holds until cleared with both safe-off lines high and no limit hit
	// enable request has no effect while in fault

	always_comb begin
		st_nxt  = st_r;
		err_nxt = error_code_o;
		unique case (st_r)
			IOSVL_ST_OFF: begin
				if (lim_hit) begin
					st_nxt  = IOSVL_ST_FAULT;
					err_nxt = IOSVL_ERR_LIMIT_SW;
				end else if (enable_req_i && !sto_trig) begin
					st_nxt = IOSVL_ST_ON;
				end
			end
			IOSVL_ST_ON: begin
				if (sto_trig) begin
					st_nxt  = IOSVL_ST_FAULT;
					err_nxt = IOSVL_ERR_SAFE_OFF;
				end else if (lim_hit) begin
					st_nxt  = IOSVL_ST_FAULT;
					err_nxt = IOSVL_ERR_LIMIT_SW;
				end else if (!enable_req_i) begin
					st_nxt = IOSVL_ST_OFF;
				end
			end
			IOSVL_ST_FAULT: begin
				if (fault_clear_i && !sto_trig && !lim_hit) begin
					st_nxt  = IOSVL_ST_OFF;
					err_nxt = IOSVL_ERR_NONE;
				end
			end
			default: begin
				st_nxt = IOSVL_ST_OFF;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_r         <= IOSVL_ST_OFF;
			error_code_o <= IOSVL_ERR_NONE;
		end else begin
			st_r         <= st_nxt;
			error_code_o <= err_nxt;
		end
	end

	assign power_stage_on_o = (st_r == IOSVL_ST_ON);
	assign brake_engage_o   = ~power_stage_on_o;
	assign error_o          = (st_r == IOSVL_ST_FAULT);
endmodule : iosvl_top

// File: testbench/iosvl_top_assertions.sv
// checker: parameter port, brake, limit switch and safe-off reactions
`timescale 1ns/1ns
module iosvl_top_assertions
	import iosvl_pkg::*;
(
	input wire logic        ref_clk_i,
	input wire logic        nrst_i,
	input wire logic [15:0] par_addr_i,
	input wire logic        par_rd_i,
	input wire logic        par_wr_i,
	input wire logic [31:0] par_wdata_i,
	input wire logic        par_ack_o,
	input wire logic        par_err_o,
	input wire logic        safe_off_channel_a_i,
	input wire logic        safe_off_channel_b_i,
	input wire logic [31:0] motor_vel_max_i,
	input wire logic [1:0]  limit_sw_i,
	input wire logic [1:0]  limit_sw_en_i,
	input wire logic [1:0]  limit_sw_nc_i,
	input wire logic        power_stage_on_o,
	input wire logic        brake_engage_o,
	input wire logic [31:0] vel_limit_o,
	input wire logic        error_o,
	input wire logic [15:0] error_code_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_bad_vel_wr;
		par_wr_i && par_addr_i == IOSVL_OFS_MAX_VEL && (par_wdata_i == 32'h0 || par_wdata_i > IOSVL_VMAX_MAX);
	endsequence
	sequence s_safe_trip;
		power_stage_on_o && !(safe_off_channel_a_i && safe_off_channel_b_i);
	endsequence
	a_ack_after_req: assert property ((par_rd_i || par_wr_i) |=> par_ack_o)
		else $error("no ack after request");
	a_bad_vel_refused: assert property (s_bad_vel_wr |=> par_ack_o && par_err_o)
		else $error("bad velocity accepted");
	a_ro_write_err: assert property (par_wr_i && par_addr_i != IOSVL_OFS_MAX_VEL |=> par_err_o)
		else $error("read-only write accepted");
	a_brake_when_off: assert property (brake_engage_o == !power_stage_on_o)
		else $error("brake not tied to power stage");
	a_safe_trip_stop: assert property (s_safe_trip |-> ##[1:8] !power_stage_on_o)
		else $error("power stage kept on");
	a_safe_code: assert property ($rose(error_o) && $past(power_stage_on_o)
		&& !$past(safe_off_channel_a_i && safe_off_channel_b_i) |-> error_code_o == IOSVL_ERR_SAFE_OFF)
		else $error("wrong safe-off code");
	a_vel_below_motor: assert property ($past(nrst_i, 4) && $stable(motor_vel_max_i)
		|=> vel_limit_o <= $past(motor_vel_max_i)) else $error("limit above motor maximum");
	a_limit_trip_err: assert property (|(limit_sw_en_i & (limit_sw_i ^ limit_sw_nc_i))
		|-> ##[1:8] error_o) else $error("limit switch not flagged");
endmodule : iosvl_top_assertions

// File: testbench/iosvl_master.sv
// fieldbus master model: one-cycle strobes on the parameter port
`timescale 1ns/1ns
module iosvl_master (
	input  wire logic        clk_i,
	output logic      [15:0] addr_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic      [31:0] wdata_o,
	input  wire logic [31:0] rdata_i,
	input  wire logic        ack_i,
	input  wire logic        err_i
);
	initial begin
		addr_o = 16'h0;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 32'h0;
	end
	task xfer(input logic w, input logic [15:0] a, input logic [31:0] wd, output logic [31:0] d,
		output logic [1:0] ae);
		@(posedge clk_i);
		#1;
		addr_o = a;
		wdata_o = wd;
		rd_o = !w;
		wr_o = w;
		@(posedge clk_i);
		#1;
		d = rdata_i;
		ae = {ack_i, err_i};
		rd_o = 1'b0;
		wr_o = 1'b0;
		// released bus shows no stale value
		addr_o = ~a;
		wdata_o = ~wd;
	endtask : xfer
endmodule : iosvl_master

// File: testbench/iosvl_top_tb_top.sv
// testbench top: parameter access, status words and drive reactions
`timescale 1ns/1ns
module iosvl_top_tb_top;
	import iosvl_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [15:0] par_addr_i, disp_data_o, error_code_o;
	logic [15:0] disp_addr_i = 16'h0802;
	logic        par_rd_i, par_wr_i, par_ack_o, par_err_o, power_stage_on_o, brake_engage_o, error_o;
	logic [31:0] par_wdata_i, par_rdata_o, vel_limit_o;
	logic [31:0] motor_vel_max_i = 32'hffff_ffff;
	logic [31:0] input_vel_lim_i = 32'h0000_0005;
	logic        input_vel_lim_en_i = 1'b0;
	logic        enable_req_i = 1'b0;
	logic        fault_clear_i = 1'b0;
	logic [7:0]  pins = 8'hc0;
	logic [1:0]  limit_sw_i = 2'h3;
	logic [1:0]  limit_sw_en_i = 2'h0;
	logic [1:0]  limit_sw_nc_i = 2'h3;
	logic [15:0] ofs [4] = '{IOSVL_OFS_IO_STATE, IOSVL_OFS_INPUT_STATE, IOSVL_OFS_OUT_STATE, IOSVL_OFS_SAFE_OFF};
	logic [7:0]  pat [4] = '{8'hff, 8'h00, 8'ha5, 8'h5a};
	logic [15:0] ew [4];
	int          miscompares = 0;
	int          compares = 0;
	iosvl_top u_iosvl_top (.ref_clk_i, .nrst_i, .par_addr_i, .par_rd_i, .par_wr_i, .par_wdata_i, .par_rdata_o,
		.par_ack_o, .par_err_o, .disp_addr_i, .disp_data_o, .input_line_zero_i(pins[0]),
		.input_line_one_i(pins[1]), .input_line_two_i(pins[2]), .input_line_three_i(pins[3]),
		.output_line_zero_i(pins[4]), .output_line_one_i(pins[5]), .safe_off_channel_a_i(pins[6]),
		.safe_off_channel_b_i(pins[7]), .motor_vel_max_i, .input_vel_lim_i, .input_vel_lim_en_i, .limit_sw_i,
		.limit_sw_en_i, .limit_sw_nc_i, .enable_req_i, .fault_clear_i, .power_stage_on_o, .brake_engage_o,
		.vel_limit_o, .error_o, .error_code_o);
	iosvl_master u_iosvl_master (.clk_i(ref_clk_i), .addr_o(par_addr_i), .rd_o(par_rd_i), .wr_o(par_wr_i),
		.wdata_o(par_wdata_i), .rdata_i(par_rdata_o), .ack_i(par_ack_o), .err_i(par_err_o));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task rw(input logic w, input logic [15:0] a, input logic [31:0] wd, input logic [31:0] ed, input logic ee);
		logic [31:0] d;
		logic [1:0]  ae;
		u_iosvl_master.xfer(w, a, wd, d, ae);
		chk({30'h0, ae}, {30'h0, 1'b1, ee});
		if (!w) chk(d, ed);
	endtask : rw
	task cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : cyc
	task clr;
		fault_clear_i = 1'b1;
		cyc(8);
		fault_clear_i = 1'b0;
		cyc(8);
	endtask : clr
	task results;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	initial forever #2 ref_clk_i = ~ref_clk_i;
	initial begin
		#20000;
		miscompares++;
		results();
	end
	initial begin
		repeat (10) @(posedge ref_clk_i);
		#1 nrst_i = 1'b1;
		cyc(8);
		chk(vel_limit_o, 32'h0000_3390);
		rw(0, IOSVL_OFS_MAX_VEL, 0, 32'h0000_3390, 0);
		rw(1, IOSVL_OFS_MAX_VEL, 32'h0000_0064, 0, 0);
		cyc(2);
		chk(vel_limit_o, 32'h0000_0064);
		motor_vel_max_i = 32'h0000_0032;
		cyc(3);
		chk(vel_limit_o, 32'h0000_0032);
		input_vel_lim_en_i = 1'b1;
		cyc(3);
		chk(vel_limit_o, 32'd5);
		input_vel_lim_en_i = 1'b0;
		motor_vel_max_i = 32'hffff_ffff;
		rw(1, IOSVL_OFS_MAX_VEL, 32'h0, 0, 1);
		rw(1, IOSVL_OFS_MAX_VEL, 32'h8000_0000, 0, 1);
		rw(0, IOSVL_OFS_MAX_VEL, 0, 32'h0000_0064, 0);
		rw(1, IOSVL_OFS_MAX_VEL, IOSVL_VMAX_MAX, 0, 0);
		rw(0, IOSVL_OFS_MAX_VEL, 0, IOSVL_VMAX_MAX, 0);
		rw(1, IOSVL_OFS_IO_STATE, 32'hffff, 0, 1);
		rw(0, 16'h0004, 0, 0, 1);
		foreach (pat[k]) begin
			pins = pat[k];
			cyc(8);
			ew = '{{6'h0, pins[5:4], 4'h0, pins[3:0]}, {12'h0, pins[3:0]}, {14'h0, pins[5:4]}, {14'h0, pins[7:6]}};
			for (int j = 0; j < 4; j++) begin
				rw(0, ofs[j], 0, {16'h0, ew[j]}, 0);
				disp_addr_i = ofs[j];
				cyc(2);
				chk({16'h0, disp_data_o}, {16'h0, ew[j]});
			end
		end
		pins = 8'hff;
		// power stage raised by request only, never armed automatically
		enable_req_i = 1'b1;
		cyc(8);
		chk({29'h0, power_stage_on_o, brake_engage_o, error_o}, 32'h4);
		pins[6] = 1'b0;
		cyc(8);
		chk({29'h0, power_stage_on_o, brake_engage_o, error_o}, 32'h3);
		chk({16'h0, error_code_o}, {16'h0, IOSVL_ERR_SAFE_OFF});
		pins[6] = 1'b1;
		clr();
		chk({29'h0, power_stage_on_o, brake_engage_o, error_o}, 32'h4);
		limit_sw_en_i = 2'h1;
		limit_sw_i = 2'h2;
		cyc(8);
		chk({16'h0, error_code_o}, {16'h0, IOSVL_ERR_LIMIT_SW});
		chk({31'h0, error_o}, 32'h1);
		limit_sw_nc_i = 2'h2;
		clr();
		chk({31'h0, error_o}, 32'h0);
		limit_sw_i = 2'h3;
		cyc(8);
		chk({31'h0, error_o}, 32'h1);
		limit_sw_en_i = 2'h0;
		clr();
		chk({31'h0, error_o}, 32'h0);
		// request dropped, then a second reset in mid-run restores the setting with the power stage already off
		enable_req_i = 1'b0;
		rw(1, IOSVL_OFS_MAX_VEL, 32'h0000_0064, 0, 0);
		nrst_i = 1'b0;
		cyc(2);
		chk({29'h0, power_stage_on_o, brake_engage_o, error_o}, 32'h2);
		chk(vel_limit_o, 32'h0000_3390);
		nrst_i = 1'b1;
		cyc(8);
		rw(0, IOSVL_OFS_MAX_VEL, 0, 32'h0000_3390, 0);
		results();
	end
endmodule : iosvl_top_tb_top
bind iosvl_top iosvl_top_assertions u_iosvl_top_assertions (.ref_clk_i, .nrst_i, .par_addr_i, .par_rd_i,
	.par_wr_i, .par_wdata_i, .par_ack_o, .par_err_o, .safe_off_channel_a_i, .safe_off_channel_b_i,
	.motor_vel_max_i, .limit_sw_i, .limit_sw_en_i, .limit_sw_nc_i, .power_stage_on_o, .brake_engage_o,
	.vel_limit_o, .error_o, .error_code_o);
